// ### hw/cpd_pkg.sv
/*
  cpd_pkg: constants shared by the configuration port decoder ends.
  assumes a 100 MHz sys_clk and an isa-style 16-bit i/o address space.
*/
package cpd_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int IO_STROBE_NS = 40;
  localparam int IO_STROBE_CYC = (IO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] IO_STROBE_CNT = 3'(IO_STROBE_CYC);

  // config port bases chosen by the strap
  localparam logic [15:0] BASE_STRAP_LOW = 16'h03F0;
  localparam logic [15:0] BASE_STRAP_HIGH = 16'h0370;
  localparam logic [15:0] DATA_PORT_STEP = 16'h0001;

  // access keys
  localparam logic [7:0] KEY_ENTER = 8'h55;
  localparam logic [7:0] KEY_EXIT = 8'hAA;

  // configuration register indices
  localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_DEV_ID = 8'h20;
  localparam logic [7:0] IDX_DEV_REV = 8'h21;
  localparam logic [7:0] IDX_PWR_CTL = 8'h22;
  localparam logic [7:0] IDX_PORT_BASE_LOW = 8'h26;
  localparam logic [7:0] IDX_PORT_BASE_HIGH = 8'h27;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam int CFG_CTRL_SOFT_RST_BIT = 0;

  // reset values
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [7:0] RST_LDN = 8'h00;
  localparam logic [7:0] RST_PWR_CTL = 8'h00;
  localparam int NUM_LD = 4;
  localparam logic [NUM_LD-1:0] RST_ACTIVATE = 4'h0;

  // controller register map on ahb-lite
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_ADDR_OFS = 8'h04;
  localparam logic [7:0] HOST_WDATA_OFS = 8'h08;
  localparam logic [7:0] HOST_CMD_OFS = 8'h0C;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h10;
  localparam int CTRL_RESET_DRV_BIT = 0;
  localparam int CTRL_STRAP_BIT = 1;
  localparam int CTRL_AEN_BIT = 2;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam logic [2:0] RST_HOST_CTRL = 3'h0;
  localparam logic [15:0] RST_HOST_ADDR = 16'h0000;
  localparam logic [7:0] RST_HOST_DATA = 8'h00;

  typedef enum logic [1:0] {
    CPD_RUN = 2'b01,
    CPD_CONFIG = 2'b10
  } cpd_mode_e;

  typedef enum logic [3:0] {
    CPD_H_IDLE = 4'b0001,
    CPD_H_SETUP = 4'b0010,
    CPD_H_STROBE = 4'b0100,
    CPD_H_HOLD = 4'b1000
  } cpd_hstate_e;
endpackage : cpd_pkg

// ### hw/cpd_isa_if.sv
/*
  cpd_isa_if: isa-style i/o bus between controller and decoder.
  assumes one sys_clk for both ends; resolves the shared data wire.
*/
`timescale 1ns/10ps
interface cpd_isa_if;
  logic [15:0] sa;
  logic aen;
  logic iow_n;
  logic ior_n;
  logic reset_drv;
  logic strap;
  logic [7:0] d_host;
  logic d_host_oe;
  logic [7:0] d_dev;
  logic d_dev_oe;
  logic [7:0] d_bus;

  // bus level from the drivers; floats high when nobody drives
  assign d_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hFF);

  modport dev (
    input sa, aen, iow_n, ior_n, reset_drv, strap, d_bus,
    output d_dev, d_dev_oe
  );
  modport host (
    output sa, aen, iow_n, ior_n, reset_drv, strap, d_host, d_host_oe,
    input d_bus
  );
endinterface : cpd_isa_if

// ### hw/cpd_dev.sv
/*
  cpd_dev: configuration port decoder of the i/o controller.
  holds the two-state access machine (run and configuration), the key and
  index port at the config port base, the data port one address above it,
  the global registers (logical device number, power control, the two port
  base bytes, identity bytes) and one activate bit per logical device.
  the config port base is taken from the strap under power-on reset and at bus reset release, and may
  then be moved by the host through the two port base registers.
  outputs show the activate bits, the mode, the port base and power control.
  assumes bus pins synchronous to sys_clk and a host keeping the key order.
  assumes each strobe is seen low at one edge at least and high at one edge
  between two cycles, so that one strobe acts exactly once.
  assumes the host end runs on the same sys_clk.
  assumes ce is high whenever bus traffic is expected: a frozen decoder
  misses strobes.
  assumes the data wire is resolved outside, floating high when undriven.
*/
`timescale 1ns/10ps
module cpd_dev
  import cpd_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h5A,  // arbitrary value
  parameter logic [7:0] DEV_REV = 8'h01  // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  cpd_isa_if.dev isa,
  output logic [cpd_pkg::NUM_LD-1:0] ld_enable,
  output logic config_mode,
  output logic [15:0] port_base,
  output logic [7:0] pwr_ctl
);
  import cpd_pkg::*;

  typedef struct packed {
    cpd_mode_e mode;
    logic iow_n_prev;
    logic rst_drv_prev;
    logic [7:0] index;
    logic [7:0] ldn;
    logic [7:0] pwr;
    logic [15:0] base;
    logic [NUM_LD-1:0] act;
    logic [7:0] rd;
  } cpd_dev_s;

  cpd_dev_s st_q;
  cpd_dev_s st_d;

  logic base_hit;
  logic data_hit;
  logic wr_edge;
  logic ld_valid;
  logic [7:0] rd_val;
  logic [NUM_LD-1:0] act_wr;
  logic [15:0] strap_base;
  logic wr_key;
  logic wr_data;
  logic rd_data;
  logic [NUM_LD-1:0] act_next;

  // strap level seen all the time; latched only under power-on reset and at bus reset release
  assign strap_base = isa.strap ? BASE_STRAP_HIGH : BASE_STRAP_LOW;

  // address decode, only for non-dma cycles
  assign base_hit = !isa.aen && (isa.sa == st_q.base);
  assign data_hit = !isa.aen && (isa.sa == st_q.base + DATA_PORT_STEP)
                    && (st_q.mode == CPD_CONFIG);
  // falling strobe edge, previous sample kept in the state
  assign wr_edge = st_q.iow_n_prev && !isa.iow_n;
  // numbers past the last device make activate a no-op
  assign ld_valid = st_q.ldn < 8'(NUM_LD);

  // one strobe per port and direction; a long strobe acts once
  assign wr_key = wr_edge && base_hit;
  assign wr_data = wr_edge && data_hit;
  assign rd_data = !isa.ior_n && data_hit;

  // per-device activate decode, one per logical device
  genvar g;
  generate
    for (g = 0; g < NUM_LD; g++) begin : g_act
      assign act_wr[g] = (st_q.ldn == 8'(g));
      assign act_next[g] = act_wr[g] ? isa.d_bus[0] : st_q.act[g];
    end
  endgenerate

  // read mux for the data port
  always_comb begin
    rd_val = 8'h00;
    case (st_q.index)
      IDX_LDN: rd_val = st_q.ldn;
      // identity bytes are fixed; writes to them are dropped
      IDX_DEV_ID: rd_val = DEV_ID;
      IDX_DEV_REV: rd_val = DEV_REV;
      IDX_PWR_CTL: rd_val = st_q.pwr;
      IDX_PORT_BASE_LOW: rd_val = st_q.base[7:0];
      IDX_PORT_BASE_HIGH: rd_val = st_q.base[15:8];
      IDX_ACTIVATE: begin
        if (ld_valid) begin
          rd_val = {7'h00, |(st_q.act & act_wr)};
        end
      end
      default: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.iow_n_prev = isa.iow_n;
    st_d.rst_drv_prev = isa.reset_drv;
    if (sys_rst || isa.reset_drv) begin
      // hard reset through the bus pin or power-on
      st_d.mode = CPD_RUN;
      st_d.act = RST_ACTIVATE;
      st_d.index = RST_INDEX;
      st_d.ldn = RST_LDN;
      st_d.pwr = RST_PWR_CTL;
      st_d.rd = 8'h00;
      // bus reset keeps the base; the strap is taken again at its release
      if (sys_rst) begin
        st_d.base = strap_base;
        st_d.iow_n_prev = 1'b1;
        st_d.rst_drv_prev = 1'b0;
      end
    end else begin
      if (st_q.rst_drv_prev) begin
        // falling edge of the bus reset
        st_d.base = strap_base;
      end
      if (rd_data) begin
        st_d.rd = rd_val;
      end
      if (wr_key) begin
        case (st_q.mode)
          CPD_RUN: begin
            if (isa.d_bus == KEY_ENTER) begin
              st_d.mode = CPD_CONFIG;
            end
          end
          CPD_CONFIG: begin
            if (isa.d_bus == KEY_EXIT) begin
              st_d.mode = CPD_RUN;
            end else begin
              // any other value, the entry key included, selects a register
              st_d.index = isa.d_bus;
            end
          end
          default: st_d.mode = CPD_RUN;
        endcase
      end else if (wr_data) begin
        case (st_q.index)
          // a soft reset keeps the port base and the index
          IDX_CFG_CTRL: begin
            if (isa.d_bus[CFG_CTRL_SOFT_RST_BIT]) begin
              st_d.ldn = RST_LDN;
              st_d.pwr = RST_PWR_CTL;
              st_d.act = RST_ACTIVATE;
            end
          end
          IDX_LDN: st_d.ldn = isa.d_bus;
          IDX_PWR_CTL: st_d.pwr = isa.d_bus;
          // the base moves after each byte; the next access uses the new port
          IDX_PORT_BASE_LOW: st_d.base[7:0] = isa.d_bus;
          IDX_PORT_BASE_HIGH: st_d.base[15:8] = isa.d_bus;
          IDX_ACTIVATE: begin
            if (ld_valid) begin
              st_d.act = act_next;
            end
          end
          default: st_d.index = st_q.index;
        endcase
      end
    end
  end

  // power-on reset acts even while ce holds everything else; the bus reset waits for ce
  always_ff @(posedge sys_clk) begin
    if (sys_rst || ce) begin
      st_q <= st_d;
    end
  end

  // read data is registered; the enable follows the strobe at once
  assign isa.d_dev = st_q.rd;
  assign isa.d_dev_oe = rd_data && !isa.reset_drv;
  assign ld_enable = st_q.act;
  assign config_mode = (st_q.mode == CPD_CONFIG);
  assign port_base = st_q.base;
  assign pwr_ctl = st_q.pwr;
endmodule : cpd_dev

// ### hw/cpd_host.sv
/*
  cpd_host: ahb-lite controlled isa i/o master driving the decoder.
  assumes one ahb-lite master, single word transfers, sys_clk as hclk.
*/
`timescale 1ns/10ps
module cpd_host
  import cpd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  cpd_isa_if.host isa
);
  import cpd_pkg::*;

  typedef struct packed {
    cpd_hstate_e fsm;
    logic [2:0] cnt;
    logic [2:0] ctrl;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdata;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
  } cpd_host_s;

  cpd_host_s st_q;
  cpd_host_s st_d;
  logic [31:0] rd_word;
  logic busy;

  assign busy = (st_q.fsm != CPD_H_IDLE);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      HOST_CTRL_OFS: rd_word = {29'h0000_0000, st_q.ctrl};
      HOST_ADDR_OFS: rd_word = {16'h0000, st_q.addr};
      HOST_WDATA_OFS: rd_word = {24'h00_0000, st_q.wdata};
      HOST_STATUS_OFS: rd_word = {16'h0000, st_q.rdata, 7'h00, busy};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_d = st_q;
    if (sys_rst) begin
      st_d.fsm = CPD_H_IDLE;
      st_d.cnt = 3'h0;
      st_d.ctrl = RST_HOST_CTRL;
      st_d.addr = RST_HOST_ADDR;
      st_d.wdata = RST_HOST_DATA;
      st_d.wr = 1'b0;
      st_d.rdata = RST_HOST_DATA;
      st_d.ap_valid = 1'b0;
      st_d.ap_write = 1'b0;
      st_d.ap_addr = 8'h00;
      st_d.hrdata = 32'h0000_0000;
    end else begin
      // address phase capture
      st_d.ap_valid = hsel && htrans[1] && hready;
      st_d.ap_write = hwrite;
      st_d.ap_addr = haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        st_d.hrdata = rd_word;
      end
      // data phase write
      if (st_q.ap_valid && st_q.ap_write) begin
        case (st_q.ap_addr)
          HOST_CTRL_OFS: st_d.ctrl = hwdata[2:0];
          HOST_ADDR_OFS: begin
            if (!busy) begin
              st_d.addr = hwdata[15:0];
            end
          end
          HOST_WDATA_OFS: begin
            if (!busy) begin
              st_d.wdata = hwdata[7:0];
            end
          end
          HOST_CMD_OFS: begin
            if (!busy && hwdata[CMD_GO_BIT]) begin
              st_d.fsm = CPD_H_SETUP;
              st_d.wr = hwdata[CMD_WRITE_BIT];
            end
          end
          default: st_d.ctrl = st_q.ctrl;
        endcase
      end
      // isa cycle sequencer
      case (st_q.fsm)
        CPD_H_IDLE: st_d.cnt = 3'h0;
        CPD_H_SETUP: begin
          st_d.fsm = CPD_H_STROBE;
          st_d.cnt = IO_STROBE_CNT - 3'h1;
        end
        CPD_H_STROBE: begin
          if (st_q.cnt == 3'h0) begin
            st_d.fsm = CPD_H_HOLD;
            if (!st_q.wr) begin
              st_d.rdata = isa.d_bus;
            end
          end else begin
            st_d.cnt = st_q.cnt - 3'h1;
          end
        end
        CPD_H_HOLD: st_d.fsm = CPD_H_IDLE;
        default: st_d.fsm = CPD_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || ce) begin
      st_q <= st_d;
    end
  end

  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = st_q.hrdata;
  assign isa.sa = st_q.addr;
  assign isa.aen = st_q.ctrl[CTRL_AEN_BIT];
  assign isa.reset_drv = st_q.ctrl[CTRL_RESET_DRV_BIT];
  assign isa.strap = st_q.ctrl[CTRL_STRAP_BIT];
  assign isa.iow_n = !((st_q.fsm == CPD_H_STROBE) && st_q.wr);
  assign isa.ior_n = !((st_q.fsm == CPD_H_STROBE) && !st_q.wr);
  assign isa.d_host = st_q.wdata;
  assign isa.d_host_oe = busy && st_q.wr;
endmodule : cpd_host

// ### tb/cpd_asserts.sv
/*
  cpd_asserts: concurrent checks on the isa link and the decoder state.
  assumes one sys_clk for both ends and ce held high.
*/
`timescale 1ns/10ps
module cpd_asserts
  import cpd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [15:0] sa,
  input wire logic aen,
  input wire logic iow_n,
  input wire logic ior_n,
  input wire logic reset_drv,
  input wire logic strap,
  input wire logic [7:0] d_bus,
  input wire logic d_dev_oe,
  input wire logic config_mode,
  input wire logic [15:0] port_base,
  input wire logic [cpd_pkg::NUM_LD-1:0] ld_enable
);
  import cpd_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // start of a qualified write strobe at one address
  sequence s_wr(a);
    $fell(iow_n) && !aen && !reset_drv && sa == a;
  endsequence

  property p_enter;
    s_wr(port_base) ##0 (!config_mode && d_bus == KEY_ENTER) |=> config_mode;
  endproperty
  property p_exit;
    s_wr(port_base) ##0 (config_mode && d_bus == KEY_EXIT) |=> !config_mode;
  endproperty
  property p_other;
    s_wr(port_base) ##0 (config_mode ? d_bus != KEY_EXIT : d_bus != KEY_ENTER)
      |=> $stable(config_mode);
  endproperty
  property p_aen;
    $fell(iow_n) && aen && !reset_drv
      |=> $stable(config_mode) && $stable(port_base) && $stable(ld_enable);
  endproperty
  property p_run_data;
    s_wr(port_base + DATA_PORT_STEP) ##0 !config_mode |=> $stable(ld_enable) && $stable(port_base);
  endproperty
  property p_hard;
    reset_drv |=> !config_mode && ld_enable == '0;
  endproperty
  property p_strap;
    $fell(reset_drv) |=> port_base == ($past(strap) ? BASE_STRAP_HIGH : BASE_STRAP_LOW);
  endproperty
  property p_rd_oe;
    d_dev_oe |-> !ior_n && config_mode && !aen && sa == port_base + DATA_PORT_STEP;
  endproperty

  a_enter: assert property (p_enter) else $error("entry key not taken");
  a_exit: assert property (p_exit) else $error("exit key not taken");
  a_other: assert property (p_other) else $error("mode moved on other value");
  a_aen: assert property (p_aen) else $error("write taken with aen high");
  a_run_data: assert property (p_run_data) else $error("data port live in run");
  a_hard: assert property (p_hard) else $error("hard reset did not clear");
  a_strap: assert property (p_strap) else $error("strap base wrong");
  a_rd_oe: assert property (p_rd_oe) else $error("read driven off data port");
endmodule : cpd_asserts

// ### tb/test_config_port_decoder.sv
/*
  test_config_port_decoder: both ends joined, driven over ahb-lite.
  assumes ce tied high, one 100 MHz clock.
*/
`timescale 1ns/10ps
module test_config_port_decoder;
  import cpd_pkg::*;
  logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, config_mode;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] port_base;
  logic [7:0] pwr_ctl, rb;
  logic [NUM_LD-1:0] ld_enable;
  int n_errors, check_count;

  cpd_isa_if isa_bus ();
  cpd_dev i_cpd_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(1'b1), .isa(isa_bus),
    .ld_enable(ld_enable), .config_mode(config_mode), .port_base(port_base), .pwr_ctl(pwr_ctl));
  cpd_host i_cpd_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .isa(isa_bus));
  cpd_asserts i_cpd_asserts (.sys_clk(sys_clk), .sys_rst(sys_rst), .sa(isa_bus.sa),
    .aen(isa_bus.aen), .iow_n(isa_bus.iow_n), .ior_n(isa_bus.ior_n),
    .reset_drv(isa_bus.reset_drv), .strap(isa_bus.strap), .d_bus(isa_bus.d_bus),
    .d_dev_oe(isa_bus.d_dev_oe), .config_mode(config_mode), .port_base(port_base),
    .ld_enable(ld_enable));

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk

  // wait for hready under a bound
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      chk(1'b0, "hready timeout");
      finish_test();
    end
  endtask : wt

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= 32'(a);
    hwrite <= w;
    wt();
    htrans <= 2'b00;
    hwdata <= wd;
    wt();
    rd = hrdata;
  endtask : ahb

  // one isa cycle through the host, polled to completion
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    int n;
    ahb(1'b1, HOST_ADDR_OFS, 32'(a), q);
    ahb(1'b1, HOST_WDATA_OFS, 32'(d), q);
    ahb(1'b1, HOST_CMD_OFS, {30'h0000_0000, w, 1'b1}, q);
    n = 0;
    q = 32'h0000_0001;
    while (q[0] !== 1'b0 && n < 50) begin
      ahb(1'b0, HOST_STATUS_OFS, 32'h0000_0000, q);
      n++;
    end
    if (q[0] !== 1'b0) begin
      chk(1'b0, "isa cycle hung");
      finish_test();
    end
    rb = q[15:8];
  endtask : io

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io(1'b1, a, d);
  endtask : wr

  task automatic t_reset();
    chk(config_mode === 1'b0 && ld_enable === 4'h0, "not run after reset");
    chk(port_base === BASE_STRAP_LOW, "base after reset");
    ahb(1'b0, 8'h14, 32'h0000_0000, r);
    chk(r === 32'h0000_0000, "unmapped read");
    chk(hresp === 1'b0, "response not okay");
  endtask : t_reset

  task automatic t_keys(input logic [15:0] b);
    wr(b, IDX_ACTIVATE);
    wr(b + DATA_PORT_STEP, 8'h01);
    chk(config_mode === 1'b0 && ld_enable === 4'h0, "run mode access acted");
    wr(b, KEY_ENTER);
    chk(config_mode === 1'b1, "entry key ignored");
    wr(b, KEY_ENTER);
    chk(config_mode === 1'b1, "second entry left config");
    wr(b, IDX_LDN);
    wr(b + DATA_PORT_STEP, 8'h02);
    wr(b, IDX_ACTIVATE);
    wr(b + DATA_PORT_STEP, 8'h01);
    chk(ld_enable === 4'h4, "activate of device 2");
    io(1'b0, b + DATA_PORT_STEP, 8'h00);
    chk(rb === 8'h01, "activate readback");
    wr(b, IDX_LDN);
    io(1'b0, b + DATA_PORT_STEP, 8'h00);
    chk(rb === 8'h02, "device number readback");
    wr(b, IDX_PWR_CTL);
    wr(b + DATA_PORT_STEP, 8'h5C);
    chk(pwr_ctl === 8'h5C, "global reg with ldn 2");
    wr(b, IDX_CFG_CTRL);
    wr(b + DATA_PORT_STEP, 8'h01);
    chk(ld_enable === 4'h0 && pwr_ctl === 8'h00, "soft reset");
    wr(b, KEY_EXIT);
    chk(config_mode === 1'b0, "exit key ignored");
  endtask : t_keys

  task automatic t_aen();
    ahb(1'b1, HOST_CTRL_OFS, 32'h0000_0004, r);
    wr(BASE_STRAP_LOW, KEY_ENTER);
    ahb(1'b1, HOST_CTRL_OFS, 32'h0000_0000, r);
    chk(config_mode === 1'b0, "write with aen taken");
  endtask : t_aen

  task automatic t_hard();
    wr(BASE_STRAP_LOW, KEY_ENTER);
    wr(BASE_STRAP_LOW, IDX_ACTIVATE);
    wr(BASE_STRAP_LOW + DATA_PORT_STEP, 8'h01);
    ahb(1'b1, HOST_CTRL_OFS, 32'h0000_0003, r);
    repeat (2) @(posedge sys_clk);
    chk(config_mode === 1'b0 && ld_enable === 4'h0, "hard reset");
    ahb(1'b1, HOST_CTRL_OFS, 32'h0000_0002, r);
    repeat (2) @(posedge sys_clk);
    chk(port_base === BASE_STRAP_HIGH, "strap high base");
  endtask : t_hard

  task automatic t_reloc();
    wr(BASE_STRAP_HIGH, KEY_ENTER);
    wr(BASE_STRAP_HIGH, IDX_PORT_BASE_LOW);
    wr(BASE_STRAP_HIGH + DATA_PORT_STEP, 8'hF0);
    chk(port_base === 16'h03F0, "relocated base");
    wr(BASE_STRAP_HIGH, KEY_EXIT);
    chk(config_mode === 1'b1, "old port still live");
    wr(16'h03F0, KEY_EXIT);
    chk(config_mode === 1'b0, "exit at new port");
  endtask : t_reloc

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    n_errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_keys(BASE_STRAP_LOW);
    t_aen();
    t_hard();
    t_reloc();
    finish_test();
  end
endmodule : test_config_port_decoder
